// [pfs_consts.svh]
// Register offsets and reset values for the pin function block.
// Assumes a byte-wide register port addressed by 7-bit register number.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
`define PFS_OFS_MPIN 7'h33
`define PFS_OFS_RSV_A 7'h34
`define PFS_OFS_RSV_B 7'h35
`define PFS_OFS_DIN 7'h36
`define PFS_OFS_RSV_C_LO 7'h37
`define PFS_OFS_RSV_C_HI 7'h3B
`define PFS_OFS_PRG 7'h3C
`define PFS_OFS_RSV_D_LO 7'h3D
`define PFS_OFS_RSV_D_HI 7'h3E
`define PFS_MPIN_TOP_RST 2'h0
`define PFS_MPIN_FUNC_RST 4'h0
`define PFS_MPIN_LVL_RST 1'h0
`define PFS_DIN_TOP_RST 5'h00
`define PFS_DIN_MODE_RST 2'h1
`define PFS_PRG_TOP_RST 3'h0
`define PFS_PRG_SEL_RST 5'h01
`endif

// [pfs_far_side.sv]
// Far-side model: outside parts on the multipurpose pin and the data pin.
// Assumes the bench sets the levels that outside parts present.
`timescale 1ns/1ps
module pfs_far_side
(
    // From the block
    input wire logic pin_oe,
    input wire logic pin_o,
    // Levels set by outside parts
    input wire logic ext_mp_lvl,
    input wire logic ext_di_lvl,
    // Resolved pin levels
    output logic mp_wire,
    output logic di_wire
);
    // Block wins while it drives, else the outside level shows
    assign mp_wire = pin_oe ? pin_o : ext_mp_lvl;
    // Data pin is input only
    assign di_wire = ext_di_lvl;
endmodule // pfs_far_side

// [pfs_pin_select.sv]
// Pin function selection, buffer power control and processing program select.
// Assumes a synchronous byte register port from the serial control bus decoder.
`timescale 1ns/1ps
`include "pfs_consts.svh"
// Notes on behaviour
// (RULE1) Function 0000 disables pin, buffers powered down
// (RULE2) Function 0001: pin is input to consumers
// (RULE3) Function 0010: general input, level read D1
// (RULE4) Function 0011: drive output level from D0
// (RULE5) Codes 0100/0101/0110 drive clock, interrupt one, two
// (RULE6) Codes 1000/1001 drive secondary bit, word clock
// (RULE7) Software writes only reset value to D7-D6
// (RULE8) Data pin mode 00 powers its buffer down
// (RULE9) Data pin mode 01 default: audio or clock
// (RULE10) Data pin mode 10 general input; 11 reserved
// (RULE11) Data pin D0 reads input buffer level
// (RULE12) Five-bit program select, reset 0 0001
// (RULE13) Software avoids program codes 0 and above 25
// (RULE14) Software writes only default to D7-D5
// (RULE15) Output level bit kept across function changes
module pfs_pin_select
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Internal sources routed to the multipurpose pin
    input wire pfs_pkg::pfs_src_t mp_src,
    // Multipurpose pin
    input wire logic multipurpose_pin_i,
    output logic multipurpose_pin_o,
    output logic multipurpose_pin_oe,
    output logic multipurpose_pin_ibuf_en,
    // Multipurpose pin as input to audio interface or clock generator
    output logic mp_input_en,
    output logic mp_input_val,
    // Serial data input pin
    input wire logic data_input_pin_i,
    output logic data_input_ibuf_en,
    output logic data_input_audio_en,
    output logic data_input_val,
    // Processing program select
    output logic [4:0] processing_program
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pfs_pkg::pfs_state_t s_q; // Registered state
    pfs_pkg::pfs_state_t s_d; // Next state
    pfs_pkg::pfs_mp_func_t mp_func; // Decoded function
    pfs_pkg::pfs_di_mode_t di_mode; // Decoded data pin mode
    logic mp_ibuf; // Multipurpose input buffer powered
    logic di_ibuf; // Data input buffer powered

    assign mp_func = pfs_pkg::pfs_mp_func_t'(s_q.mp_func);
    assign di_mode = pfs_pkg::pfs_di_mode_t'(s_q.di_mode);

    // ----------------------------------------------------------------
    // Buffer power decode
    // ----------------------------------------------------------------
    // Input buffer is live only in the input modes
    always_comb
    begin
        // Codes 0001 and 0010 listen; all others keep the buffer off
        mp_ibuf = (s_q.mp_func == 4'h1) || (s_q.mp_func == 4'h2); // see RULE1 RULE2 RULE3
        // Modes 01 and 10 listen; 00 and the reserved 11 stay off
        di_ibuf = (di_mode == pfs_pkg::PFS_DI_ON) ||
                  (di_mode == pfs_pkg::PFS_DI_GP_IN); // see RULE8 RULE10
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Register writes, pin synchronisers and read data
    always_comb
    begin
        s_d = s_q;
        // Three-stage synchronisers; only stages two and three are used
        s_d.mp_sync = {s_q.mp_sync[1:0], multipurpose_pin_i & mp_ibuf};
        s_d.di_sync = {s_q.di_sync[1:0], data_input_pin_i & di_ibuf};
        if (s_q.mp_sync[2] == s_q.mp_sync[1])
        begin
            s_d.mp_in = s_q.mp_sync[2];
        end
        if (s_q.di_sync[2] == s_q.di_sync[1])
        begin
            s_d.di_in = s_q.di_sync[2];
        end
        // Writes; level bit is only changed by writes, never by function
        if (reg_wr)
        begin
            unique case (reg_addr)
                `PFS_OFS_MPIN:
                begin
                    s_d.mp_top = reg_wdata[7:6]; // see RULE7
                    s_d.mp_func = reg_wdata[5:2];
                    s_d.mp_lvl = reg_wdata[0]; // see RULE15
                end
                `PFS_OFS_DIN:
                begin
                    s_d.di_top = reg_wdata[7:3];
                    s_d.di_mode = reg_wdata[2:1]; // see RULE10
                end
                `PFS_OFS_PRG:
                begin
                    s_d.prg_top = reg_wdata[7:5]; // see RULE14
                    s_d.prg_sel = reg_wdata[4:0]; // see RULE12 RULE13
                end
                default:
                begin
                    s_d.prg_sel = s_q.prg_sel;
                end
            endcase
        end
        // Read data, registered one cycle after the read strobe
        if (reg_rd)
        begin
            unique case (reg_addr)
                `PFS_OFS_MPIN:
                begin
                    s_d.rdata = {s_q.mp_top, s_q.mp_func, s_q.mp_in, s_q.mp_lvl}; // see RULE3
                end
                `PFS_OFS_DIN:
                begin
                    s_d.rdata = {s_q.di_top, s_q.di_mode, s_q.di_in}; // see RULE11
                end
                `PFS_OFS_PRG:
                begin
                    s_d.rdata = {s_q.prg_top, s_q.prg_sel};
                end
                default:
                begin
                    s_d.rdata = 8'h00; // Reserved and unmapped read zero
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset to documented defaults
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.mp_top <= `PFS_MPIN_TOP_RST;
            s_q.mp_func <= `PFS_MPIN_FUNC_RST; // see RULE1
            s_q.mp_lvl <= `PFS_MPIN_LVL_RST; // see RULE4
            s_q.di_top <= `PFS_DIN_TOP_RST;
            s_q.di_mode <= `PFS_DIN_MODE_RST; // see RULE9
            s_q.prg_top <= `PFS_PRG_TOP_RST;
            s_q.prg_sel <= `PFS_PRG_SEL_RST; // see RULE12
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin output mux
    // ----------------------------------------------------------------
    // Picks the driven source; reserved codes leave the pin undriven
    always_comb
    begin
        multipurpose_pin_o = 1'b0;
        multipurpose_pin_oe = 1'b1;
        unique case (s_q.mp_func)
            4'h3: multipurpose_pin_o = s_q.mp_lvl; // see RULE4
            4'h4: multipurpose_pin_o = mp_src.clock_output; // see RULE5
            4'h5: multipurpose_pin_o = mp_src.first_interrupt_output; // see RULE5
            4'h6: multipurpose_pin_o = mp_src.second_interrupt_output; // see RULE5
            4'h8: multipurpose_pin_o = mp_src.bclk2; // see RULE6
            4'h9: multipurpose_pin_o = mp_src.wclk2; // see RULE6
            default: multipurpose_pin_oe = 1'b0; // see RULE1
        endcase
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Buffer enables and routing flags follow the stored settings directly
    assign multipurpose_pin_ibuf_en = mp_ibuf;
    assign mp_input_en = (mp_func == pfs_pkg::PFS_MP_IN); // see RULE2
    assign mp_input_val = s_q.mp_in;
    assign data_input_ibuf_en = di_ibuf;
    assign data_input_audio_en = (di_mode == pfs_pkg::PFS_DI_ON); // see RULE9
    assign data_input_val = s_q.di_in;
    // Settings and read data come straight from flip-flops
    assign processing_program = s_q.prg_sel;
    assign reg_rdata = s_q.rdata;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Named sequences for the multi-step synchroniser checks
    // Multipurpose pin high with its buffer powered, long enough to pass all stages
    sequence s_mp_high_held;
        (multipurpose_pin_i && multipurpose_pin_ibuf_en) [*5];
    endsequence
    // Multipurpose pin low, or its buffer off, for as long
    sequence s_mp_low_held;
        (!multipurpose_pin_i || !multipurpose_pin_ibuf_en) [*5];
    endsequence
    // Data pin high with its buffer powered
    sequence s_di_high_held;
        (data_input_pin_i && data_input_ibuf_en) [*5];
    endsequence
    // Data pin held in the disabled mode
    sequence s_di_off_held;
        (s_q.di_mode == 2'h0) [*5];
    endsequence

    // Disabled pin neither drives nor listens
    a_off_no_drive: assert property (@(posedge clk_sys) disable iff (rst) // see RULE1
        (s_q.mp_func == 4'h0) |-> (!multipurpose_pin_oe && !multipurpose_pin_ibuf_en))
        else $error("pin drives or listens while disabled");
    // Input mode feeds the consumers and never drives
    a_in_mode_en: assert property (@(posedge clk_sys) disable iff (rst) // see RULE2
        (s_q.mp_func == 4'h1) |-> (mp_input_en && !multipurpose_pin_oe))
        else $error("input mode not routed");
    // General input mode powers the buffer and does not drive
    a_gp_in_buf: assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
        (s_q.mp_func == 4'h2) |->
        (multipurpose_pin_ibuf_en && !multipurpose_pin_oe && !mp_input_en))
        else $error("general input mode buffers wrong");
    // Held high level reaches the synchronised input
    a_mp_sync_high: assert property (@(posedge clk_sys) disable iff (rst) // see RULE2
        s_mp_high_held |-> mp_input_val)
        else $error("high pin level not synchronised");
    // Low level or powered-down buffer reads as zero
    a_mp_sync_low: assert property (@(posedge clk_sys) disable iff (rst) // see RULE1
        s_mp_low_held |-> !mp_input_val)
        else $error("low pin level not synchronised");
    // Read-back carries the synchronised level in bit one
    a_gp_in_readback: assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
        (reg_rd && reg_addr == `PFS_OFS_MPIN) |=> (reg_rdata[1] == $past(s_q.mp_in)))
        else $error("pin level readback wrong");
    // Output mode drives the stored level
    a_gpo_level: assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
        (s_q.mp_func == 4'h3) |-> (multipurpose_pin_oe && multipurpose_pin_o == s_q.mp_lvl))
        else $error("output level mismatch");
    // Clock output routed to the pin
    a_clk_route: assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
        (s_q.mp_func == 4'h4) |->
        (multipurpose_pin_oe && multipurpose_pin_o == mp_src.clock_output))
        else $error("clock output route wrong");
    // First interrupt output routed to the pin
    a_irq_route: assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
        (s_q.mp_func == 4'h5) |-> (multipurpose_pin_o == mp_src.first_interrupt_output))
        else $error("interrupt route wrong");
    // Second interrupt output routed to the pin
    a_irq2_route: assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
        (s_q.mp_func == 4'h6) |->
        (multipurpose_pin_oe && multipurpose_pin_o == mp_src.second_interrupt_output))
        else $error("second interrupt route wrong");
    // Secondary bit clock routed to the pin
    a_bclk_route: assert property (@(posedge clk_sys) disable iff (rst) // see RULE6
        (s_q.mp_func == 4'h8) |->
        (multipurpose_pin_oe && multipurpose_pin_o == mp_src.bclk2))
        else $error("bit clock route wrong");
    // Secondary word clock routed to the pin
    a_wclk_route: assert property (@(posedge clk_sys) disable iff (rst) // see RULE6
        (s_q.mp_func == 4'h9) |-> (multipurpose_pin_o == mp_src.wclk2 && multipurpose_pin_oe))
        else $error("word clock route wrong");
    // Disabled data pin settles to zero with its buffer off
    a_din_off: assert property (@(posedge clk_sys) disable iff (rst) // see RULE8
        s_di_off_held |-> (!data_input_val && !data_input_ibuf_en))
        else $error("data pin buffer not off");
    // Audio path enabled only in mode 01
    a_din_audio: assert property (@(posedge clk_sys) disable iff (rst) // see RULE9
        data_input_audio_en |-> (s_q.di_mode == 2'h1 && data_input_ibuf_en))
        else $error("audio enable outside mode one");
    // Held high data pin reaches the synchronised level
    a_di_sync_high: assert property (@(posedge clk_sys) disable iff (rst) // see RULE9
        s_di_high_held |-> data_input_val)
        else $error("high data pin level not synchronised");
    // General input mode listens without feeding the audio path
    a_di_gp_in: assert property (@(posedge clk_sys) disable iff (rst) // see RULE10
        (s_q.di_mode == 2'h2) |-> (data_input_ibuf_en && !data_input_audio_en))
        else $error("data pin general input mode wrong");
    // Data pin read-back carries the synchronised level in bit zero
    a_din_readback: assert property (@(posedge clk_sys) disable iff (rst) // see RULE11
        (reg_rd && reg_addr == `PFS_OFS_DIN) |=> (reg_rdata[0] == $past(data_input_val)))
        else $error("data pin readback wrong");
    // Written selector becomes the active program
    a_prg_write: assert property (@(posedge clk_sys) disable iff (rst) // see RULE12
        (reg_wr && reg_addr == `PFS_OFS_PRG) |=> (processing_program == $past(reg_wdata[4:0])))
        else $error("program select not stored");
    // Leaving reset shows program one and an undriven pin
    a_reset_values: assert property (@(posedge clk_sys) disable iff (rst) // see RULE12
        $fell(rst) |-> (processing_program == `PFS_PRG_SEL_RST && !multipurpose_pin_oe))
        else $error("reset settings wrong");
    // Output level changes only on a write of its register
    a_lvl_kept: assert property (@(posedge clk_sys) disable iff (rst) // see RULE15
        !(reg_wr && reg_addr == `PFS_OFS_MPIN) |=> $stable(s_q.mp_lvl))
        else $error("output level changed without write");
endmodule // pfs_pin_select

// [pfs_pin_select_tb.sv]
// Self-checking bench for the pin function block.
// Assumes the far-side model resolves both pin levels.
`timescale 1ns/1ps
module pfs_pin_select_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    pfs_pkg::pfs_src_t mp_src = 5'h00;
    logic ext_mp_lvl = 1'b0;
    logic ext_di_lvl = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] prog;
    logic mp_wire, di_wire, pin_o, pin_oe, mp_ibuf, mp_in_en, mp_in_val;
    logic di_ibuf, di_audio, di_val;
    int n_errors = 0;
    int total_checks = 0;
    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    pfs_pin_select pfs_pin_select_i (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mp_src(mp_src), .multipurpose_pin_i(mp_wire), .multipurpose_pin_o(pin_o),
        .multipurpose_pin_oe(pin_oe), .multipurpose_pin_ibuf_en(mp_ibuf),
        .mp_input_en(mp_in_en), .mp_input_val(mp_in_val), .data_input_pin_i(di_wire),
        .data_input_ibuf_en(di_ibuf), .data_input_audio_en(di_audio),
        .data_input_val(di_val), .processing_program(prog));
    pfs_far_side pfs_far_side_i (.pin_oe(pin_oe), .pin_o(pin_o), .ext_mp_lvl(ext_mp_lvl),
        .ext_di_lvl(ext_di_lvl), .mp_wire(mp_wire), .di_wire(di_wire));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One byte write, strobe held for one edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    // One byte read, data valid the cycle after the strobe
    task automatic rdck(input string what, input logic [6:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(what, reg_rdata, exp);
    endtask
    // Let the input synchronisers settle
    task automatic settle();
        repeat (6) @(negedge clk_sys);
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset state of all three registers
    task automatic t_reset();
        chk("mp_oe", pin_oe, 0);
        chk("mp_ibuf", mp_ibuf, 0);
        rdck("mpin", 7'h33, 8'h00);
        chk("di_ibuf", di_ibuf, 1);
        chk("di_audio", di_audio, 1);
        rdck("din", 7'h36, 8'h02);
        chk("prog", prog, 8'h01);
        rdck("prg", 7'h3C, 8'h01);
    endtask
    // Function codes 0 to 9 except 7, each source seen at both levels
    task automatic t_funcs();
        logic [4:0] pat;
        logic eo;
        logic ev;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 10; c++)
            begin
                if (c == 7)
                    continue;
                pat = p[0] ? 5'h0A : 5'h15;
                wr(7'h33, {2'b00, c[3:0], 1'b0, p[0]});
                mp_src = pat;
                #1;
                eo = c inside {3, 4, 5, 6, 8, 9};
                ev = c == 3 ? p[0] : c == 4 ? pat[4] : c == 5 ? pat[3] :
                     c == 6 ? pat[2] : c == 8 ? pat[1] : pat[0];
                chk("mp_oe", pin_oe, eo);
                chk("mp_ibuf", mp_ibuf, c == 1 || c == 2);
                chk("mp_in_en", mp_in_en, c == 1);
                if (eo)
                    chk("mp_out", pin_o, ev);
            end
    endtask
    // Pin input paths and the written output level
    task automatic t_inputs();
        wr(7'h33, 8'h08);
        ext_mp_lvl = 1'b1;
        settle();
        rdck("mp_gp_in", 7'h33, 8'h0A);
        ext_mp_lvl = 1'b0;
        settle();
        rdck("mp_gp_in", 7'h33, 8'h08);
        wr(7'h33, 8'h04);
        ext_mp_lvl = 1'b1;
        settle();
        chk("mp_in_val", mp_in_val, 1);
        wr(7'h33, 8'h01);
        settle();
        rdck("mp_off", 7'h33, 8'h01);
        wr(7'h33, 8'h0D);
        chk("mp_gpo", pin_o, 1);
    endtask
    // Data pin modes and its read-back
    task automatic t_din();
        ext_di_lvl = 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            wr(7'h36, {5'h00, m[1:0], 1'b0});
            settle();
            chk("di_ibuf", di_ibuf, m != 0);
            chk("di_audio", di_audio, m == 1);
            rdck("din", 7'h36, {5'h00, m[1:0], m != 0});
        end
        chk("di_val", di_val, 1);
        wr(7'h36, 8'h02);
    endtask
    // Program selector at both ends of its range
    task automatic t_prog();
        logic [4:0] v;
        for (int i = 0; i < 3; i++)
        begin
            v = i == 0 ? 5'h19 : i == 1 ? 5'h0C : 5'h01;
            wr(7'h3C, {3'h0, v});
            chk("prog", prog, v);
            rdck("prg", 7'h3C, {3'h0, v});
        end
    endtask
    // Reserved places read as zero
    task automatic t_rsvd();
        wr(7'h37, 8'hFF);
        chk("prog_kept", prog, 8'h01);
        rdck("mpin_kept", 7'h33, 8'h0D);
        rdck("rsv_c_lo", 7'h37, 8'h00);
        rdck("rsv_a", 7'h34, 8'h00);
        rdck("rsv_b", 7'h35, 8'h00);
        rdck("rsv_c", 7'h3B, 8'h00);
        rdck("rsv_d", 7'h3E, 8'h00);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_funcs();
        t_inputs();
        t_din();
        t_prog();
        t_rsvd();
        wrap_up();
    end
    // Cut a hang short
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule // pfs_pin_select_tb

// [pfs_pkg.sv]
// Types shared by the pin function block.
// Assumes nothing beyond the constants header.
package pfs_pkg;
    // Multipurpose pin function codes
    typedef enum logic [3:0] {
        PFS_MP_OFF = 4'h0,
        PFS_MP_IN = 4'h1,
        PFS_MP_GP_IN = 4'h2,
        PFS_MP_GPO = 4'h3,
        PFS_MP_CLK = 4'h4,
        PFS_MP_IRQ1 = 4'h5,
        PFS_MP_IRQ2 = 4'h6,
        PFS_MP_BCLK2 = 4'h8,
        PFS_MP_WCLK2 = 4'h9
    } pfs_mp_func_t;
    // Data input pin modes
    typedef enum logic [1:0] {
        PFS_DI_OFF = 2'h0,
        PFS_DI_ON = 2'h1,
        PFS_DI_GP_IN = 2'h2,
        PFS_DI_RSV = 2'h3
    } pfs_di_mode_t;
    // Register state of the block
    typedef struct packed {
        logic [1:0] mp_top;
        logic [3:0] mp_func;
        logic mp_lvl;
        logic [4:0] di_top;
        logic [1:0] di_mode;
        logic [2:0] prg_top;
        logic [4:0] prg_sel;
        logic [2:0] mp_sync;
        logic [2:0] di_sync;
        logic mp_in;
        logic di_in;
        logic [7:0] rdata;
    } pfs_state_t;
    // Internal signal sources that can be routed to the multipurpose pin
    typedef struct packed {
        logic clock_output;
        logic first_interrupt_output;
        logic second_interrupt_output;
        logic bclk2;
        logic wclk2;
    } pfs_src_t;
endpackage
